// File: mpd_pkg.sv
/*
  Constants, register map and carrier types for the dead-time and culling option block.
  Assumes one 100 MHz system clock and a plain register port with 16-bit data.
*/
package mpd_pkg;
  // ------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 28;
  localparam int unsigned DATA_W = 16;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 28'hFFFF600;
  localparam logic [ADDR_W-1:0] OFS_OPT0 = 28'hFFFF605;
  localparam logic [ADDR_W-1:0] OFS_OPT1 = 28'hFFFF620;
  localparam logic [ADDR_W-1:0] OFS_OPT2 = 28'hFFFF621;
  localparam logic [ADDR_W-1:0] OFS_DTC = 28'hFFFF624;
  localparam logic [ADDR_W-1:0] OFS_CCR_BASE = 28'hFFFF640;
  localparam logic [ADDR_W-1:0] OFS_TUNED_BASE = 28'hFFFF644;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int unsigned CTRL_RUN = 7;
  localparam int unsigned CTRL_MD_LSB = 3;
  localparam int unsigned CTRL_CKS_LSB = 0;
  localparam int unsigned OPT0_CMS = 2;
  localparam int unsigned OPT0_CUF = 1;
  localparam int unsigned OPT2_RDE = 7;
  localparam int unsigned OPT2_DTM = 6;
  localparam logic [2:0] MD_SIX_PHASE = 3'h7;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'h00;
  localparam logic [15:0] DTC_RST = 16'h0000;
  localparam logic [15:0] CCR_RST = 16'h0000;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } mpd_bus_req_type;

  typedef struct packed {
    logic crest_use;
    logic valley_use;
    logic spare;
    logic [4:0] cull;
  } mpd_cull_cfg_type;

  typedef enum logic [2:0] {
    DT_IDLE = 3'b001,
    DT_UP = 3'b010,
    DT_DOWN = 3'b100
  } mpd_dt_state_type;
endpackage

// File: mpd_deadtime.sv
/*
  One dead-time channel: turns a carrier phase into upper and lower arm drives.
  Assumes phase changes only on count ticks and is held low while stopped.
*/
`timescale 1ns/100ps
module mpd_deadtime import mpd_pkg::*; #(
  parameter int unsigned DT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic [DT_W-1:0] dtc,
  input wire logic narrow,
  // carrier phase and arms
  input wire logic phase,
  output logic upper_q,
  output logic lower_q
);
  mpd_dt_state_type state_q;
  logic [DT_W-1:0] cnt_q;
  logic phase_q;
  logic edge_seen;
  logic blank;

  assign edge_seen = phase != phase_q;
  // blank in the edge cycle too, so no arm ever overlaps its partner
  assign blank = (state_q != DT_IDLE) || (edge_seen && (dtc != '0));

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      state_q <= DT_IDLE;
      cnt_q <= '0;
      phase_q <= 1'h0;
    end else begin
      phase_q <= phase;
      if (edge_seen) begin
        if (dtc == '0) begin
          state_q <= DT_IDLE;
        end else if (narrow && state_q != DT_IDLE) begin
          state_q <= DT_DOWN;
        end else begin
          cnt_q <= '0;
          state_q <= DT_UP;
        end
      end else if (tick) begin
        unique case (state_q)
          DT_UP: begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q + 1'b1 == dtc) begin
              state_q <= DT_IDLE;
            end
          end
          DT_DOWN: begin
            if (cnt_q <= 1) begin
              state_q <= DT_IDLE;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          DT_IDLE: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      upper_q <= 1'h0;
      lower_q <= 1'h0;
    end else begin
      upper_q <= run && phase && !blank;
      lower_q <= run && !phase && !blank;
    end
  end

  a_zero_dead_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && dtc == '0 && state_q == DT_IDLE |=> upper_q == $past(phase))
    else $error("zero dead time delayed the upper arm");
  a_normal_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && edge_seen && !narrow && dtc != '0 |=> state_q == DT_UP && cnt_q == '0)
    else $error("normal mode did not restart the counter");
  a_narrow_down: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && edge_seen && narrow && dtc != '0 && state_q != DT_IDLE |=> state_q == DT_DOWN)
    else $error("narrowing mode did not count down");
  a_arms_apart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(upper_q && lower_q))
    else $error("upper and lower arms both on");
endmodule

// File: mpd_cull.sv
/*
  Crest and valley interrupt culling with transfer thinning.
  Assumes crest and valley events are single-cycle pulses that never coincide.
*/
`timescale 1ns/100ps
module mpd_cull import mpd_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire mpd_cull_cfg_type cfg,
  input wire logic rde,
  // raw events
  input wire logic crest_ev,
  input wire logic valley_ev,
  // culled outputs
  output logic crest_irq_q,
  output logic valley_irq_q,
  output logic adc_trig_q,
  output logic transfer_q
);
  logic [4:0] cnt_q;
  logic counted;
  logic pass;

  assign counted = (crest_ev && cfg.crest_use) || (valley_ev && cfg.valley_use);
  assign pass = counted && (cnt_q >= cfg.cull);

  // a cull value lowered below the count passes the next event, no 5-bit wrap
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      cnt_q <= 5'h00;
    end else if (counted) begin
      cnt_q <= pass ? 5'h00 : cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      crest_irq_q <= 1'h0;
      valley_irq_q <= 1'h0;
      adc_trig_q <= 1'h0;
      transfer_q <= 1'h0;
    end else begin
      crest_irq_q <= pass && crest_ev;
      valley_irq_q <= pass && valley_ev;
      adc_trig_q <= pass;
      transfer_q <= rde ? pass : (run && (crest_ev || valley_ev));
    end
  end

  a_cull_pass_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && cfg.cull == 5'h00 && counted |=> adc_trig_q)
    else $error("unculled event was dropped");
  a_crest_unused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    crest_ev && !cfg.crest_use |=> !crest_irq_q && !adc_trig_q)
    else $error("unused crest produced an interrupt");
  a_valley_unused: assert property (@(posedge clk_sys) disable iff (!rst_n)
    valley_ev && !cfg.valley_use |=> !valley_irq_q)
    else $error("unused valley produced an interrupt");
  a_transfer_every: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !rde && (crest_ev || valley_ev) |=> transfer_q)
    else $error("transfer missing at crest or valley");
endmodule

// File: mpd_top.sv
/*
  Motor PWM option block: triangular carrier, batch or anytime compare rewrite,
  interrupt and transfer culling, and three dead-time channels for the inverter arms.
  Assumes software on a one-cycle register port and gate drivers on the arm outputs.
*/
// Our own choice: strobed register access.
`timescale 1ns/100ps
module mpd_top import mpd_pkg::*; #(
  parameter int unsigned DT_W = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire mpd_bus_req_type bus_req,
  output logic [DATA_W-1:0] rdata_q,
  // tuned timer compare values
  output logic [DATA_W-1:0] tuned_compare_zero_q,
  output logic [DATA_W-1:0] tuned_compare_one_q,
  // inverter arms
  output logic [2:0] upper_arm_outputs,
  output logic [2:0] lower_arm_outputs,
  // culled events
  output logic crest_interrupt,
  output logic valley_interrupt,
  output logic adc_trigger
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (DT_W < 1 || DT_W > DATA_W) begin : g_bad_width
    $error("dead-time width out of range");
  end

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                               input int unsigned idx);
    logic [ADDR_W-1:0] target;
    target = base + ADDR_W'(idx);
    return a == target;
  endfunction

  // prescaler mask for a count clock of clk_sys / 2^cks
  function automatic logic [6:0] div_mask(input logic [2:0] cks);
    logic [7:0] m;
    m = 8'h01 << cks;
    m = m - 8'h01;
    return m[6:0];
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic cms_q;
  logic rde_q;
  logic dtm_q;
  logic [DT_W-1:0] dtc_q;
  mpd_cull_cfg_type opt1_buf_q;
  mpd_cull_cfg_type opt1_act_q;
  logic [DATA_W-1:0] ccr_buf_q [4];
  logic [DATA_W-1:0] ccr_act_q [4];
  logic [DATA_W-1:0] tun_buf_q [2];
  logic [DATA_W-1:0] tun_act_q [2];
  logic [6:0] presc_q;
  logic [DATA_W-1:0] cnt_q;
  logic dir_q;
  logic crest_ev_q;
  logic valley_ev_q;
  logic [2:0] phase_q;
  logic [DATA_W-1:0] rdata_d;

  logic run;
  logic [2:0] cks;
  logic [2:0] md;
  logic tick;
  logic anytime;
  logic load_now;
  logic transfer;
  logic wr_dtc;

  assign run = ctrl_q[CTRL_RUN];
  assign cks = ctrl_q[CTRL_CKS_LSB +: 3];
  assign md = ctrl_q[CTRL_MD_LSB +: 3];
  // rewrite mode only counts in six-phase mode; elsewhere batch applies
  assign anytime = cms_q && (md == MD_SIX_PHASE);
  // while stopped there is no transfer, so writes land at once
  assign load_now = anytime || !run;
  assign wr_dtc = bus_req.wr && hit(bus_req.addr, OFS_DTC, 0);
  assign tuned_compare_zero_q = tun_act_q[0];
  assign tuned_compare_one_q = tun_act_q[1];

  // ------------------------------------------------------------
  // control and option registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      cms_q <= OPT_RST[OPT0_CMS];
      rde_q <= OPT_RST[OPT2_RDE];
      dtm_q <= OPT_RST[OPT2_DTM];
      dtc_q <= DTC_RST[DT_W-1:0];
    end else if (bus_req.wr) begin
      if (hit(bus_req.addr, OFS_CTRL, 0)) begin
        ctrl_q <= bus_req.wdata[7:0];
      end
      if (hit(bus_req.addr, OFS_OPT0, 0)) begin
        cms_q <= bus_req.wdata[OPT0_CMS];
      end
      if (hit(bus_req.addr, OFS_OPT2, 0)) begin
        rde_q <= bus_req.wdata[OPT2_RDE];
        // a mode change under a running carrier is dropped
        if (!run) begin
          dtm_q <= bus_req.wdata[OPT2_DTM];
        end
      end
      if (wr_dtc && !run) begin
        dtc_q <= bus_req.wdata[DT_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // buffered compare and culling registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        ccr_buf_q[i] <= CCR_RST;
        ccr_act_q[i] <= CCR_RST;
      end
      for (int i = 0; i < 2; i++) begin
        tun_buf_q[i] <= CCR_RST;
        tun_act_q[i] <= CCR_RST;
      end
      opt1_buf_q <= OPT_RST;
      opt1_act_q <= OPT_RST;
    end else begin
      // one shared transfer moves every buffered register together
      if (transfer && !load_now) begin
        ccr_act_q <= ccr_buf_q;
        tun_act_q <= tun_buf_q;
        opt1_act_q <= opt1_buf_q;
      end
      if (bus_req.wr) begin
        for (int i = 0; i < 4; i++) begin
          if (hit(bus_req.addr, OFS_CCR_BASE, i)) begin
            ccr_buf_q[i] <= bus_req.wdata;
            if (load_now) begin
              ccr_act_q[i] <= bus_req.wdata;
            end
          end
        end
        for (int i = 0; i < 2; i++) begin
          if (hit(bus_req.addr, OFS_TUNED_BASE, i)) begin
            tun_buf_q[i] <= bus_req.wdata;
            if (load_now) begin
              tun_act_q[i] <= bus_req.wdata;
            end
          end
        end
        if (hit(bus_req.addr, OFS_OPT1, 0)) begin
          opt1_buf_q <= bus_req.wdata[7:0];
          if (load_now) begin
            opt1_act_q <= bus_req.wdata[7:0];
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // count clock divider
  // ------------------------------------------------------------
  assign tick = run && ((presc_q & div_mask(cks)) == div_mask(cks));

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      presc_q <= 7'h00;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  // ------------------------------------------------------------
  // triangular carrier
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      cnt_q <= CCR_RST;
      dir_q <= 1'h0;
      crest_ev_q <= 1'h0;
      valley_ev_q <= 1'h0;
    end else begin
      crest_ev_q <= 1'h0;
      valley_ev_q <= 1'h0;
      if (tick) begin
        if (!dir_q) begin
          if (cnt_q >= ccr_act_q[0]) begin
            dir_q <= 1'h1;
            crest_ev_q <= 1'h1;
            if (cnt_q != CCR_RST) begin
              cnt_q <= cnt_q - 16'h0001;
            end
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end else begin
          if (cnt_q == CCR_RST) begin
            dir_q <= 1'h0;
            valley_ev_q <= 1'h1;
            if (ccr_act_q[0] != CCR_RST) begin
              cnt_q <= 16'h0001;
            end
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
      end
    end
  end

  // phases follow the active compares; forced low while stopped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        phase_q[i] <= run && (cnt_q < ccr_act_q[i+1]);
      end
    end
  end

  // ------------------------------------------------------------
  // culling
  // ------------------------------------------------------------
  mpd_cull u_cull (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(run),
    .cfg(opt1_act_q),
    .rde(rde_q),
    .crest_ev(crest_ev_q),
    .valley_ev(valley_ev_q),
    .crest_irq_q(crest_interrupt),
    .valley_irq_q(valley_interrupt),
    .adc_trig_q(adc_trigger),
    .transfer_q(transfer)
  );

  // ------------------------------------------------------------
  // dead-time channels
  // ------------------------------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_dt
    mpd_deadtime #(.DT_W(DT_W)) u_dt (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .run(run),
      .tick(tick),
      .dtc(dtc_q),
      .narrow(dtm_q),
      .phase(phase_q[g]),
      .upper_q(upper_arm_outputs[g]),
      .lower_q(lower_arm_outputs[g])
    );
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = 16'h0000;
    if (hit(bus_req.addr, OFS_CTRL, 0)) begin
      rdata_d = {8'h00, ctrl_q};
    end
    if (hit(bus_req.addr, OFS_OPT0, 0)) begin
      rdata_d[OPT0_CMS] = cms_q;
      rdata_d[OPT0_CUF] = dir_q;
    end
    if (hit(bus_req.addr, OFS_OPT1, 0)) begin
      rdata_d = {8'h00, opt1_buf_q};
    end
    if (hit(bus_req.addr, OFS_OPT2, 0)) begin
      rdata_d[OPT2_RDE] = rde_q;
      rdata_d[OPT2_DTM] = dtm_q;
    end
    if (hit(bus_req.addr, OFS_DTC, 0)) begin
      rdata_d[DT_W-1:0] = dtc_q;
    end
    for (int i = 0; i < 4; i++) begin
      if (hit(bus_req.addr, OFS_CCR_BASE, i)) begin
        rdata_d = ccr_buf_q[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (hit(bus_req.addr, OFS_TUNED_BASE, i)) begin
        rdata_d = tun_buf_q[i];
      end
    end
  end

  // data stand for exactly one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= bus_req.rd ? rdata_d : 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_dtc_locked: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && wr_dtc |=> dtc_q == $past(dtc_q))
    else $error("dead-time compare changed while running");
  a_stop_outputs_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !run ##1 !run |=> upper_arm_outputs == 3'h0 && lower_arm_outputs == 3'h0)
    else $error("arm outputs active while stopped");
  a_cms_write_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.wr && hit(bus_req.addr, OFS_OPT0, 0) |=> cms_q == $past(bus_req.wdata[OPT0_CMS]))
    else $error("rewrite-mode write not taken");
  a_anytime_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    anytime && bus_req.wr && hit(bus_req.addr, OFS_CCR_BASE, 1)
    |=> ccr_act_q[1] == $past(bus_req.wdata))
    else $error("anytime write did not take effect");
  a_batch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !anytime && !transfer && bus_req.wr && hit(bus_req.addr, OFS_CCR_BASE, 1)
    |=> ccr_act_q[1] == $past(ccr_act_q[1]))
    else $error("batch write reached the active compare early");
  a_batch_transfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && !anytime && transfer |=> opt1_act_q == $past(opt1_buf_q) && tun_act_q[0] == $past(tun_buf_q[0]))
    else $error("transfer did not copy buffered registers");
  a_dir_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_req.rd && hit(bus_req.addr, OFS_OPT0, 0) |=> rdata_q[OPT0_CUF] == $past(dir_q))
    else $error("direction flag read wrong");
  a_tick_full_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && cks == 3'h0 && $past(run) |-> tick)
    else $error("undivided count clock missed a cycle");
  a_valley_turn: assert property (@(posedge clk_sys) disable iff (!rst_n)
    run && tick && dir_q && cnt_q == CCR_RST |=> !dir_q && valley_ev_q)
    else $error("carrier did not turn at the valley");
endmodule

// File: mpd_gate_model.sv
/*
  Gate-driver stand-in for the three inverter legs.
  Assumes active-high arm drives sampled on the system clock.
*/
`timescale 1ns/100ps
module mpd_gate_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // arm drives
  input wire logic [2:0] upper,
  input wire logic [2:0] lower,
  // shoot-through count
  output logic [7:0] overlap_q
);
  // ------------------------------------------------------------
  // both switches of a leg on shorts the dc bus
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overlap_q <= 8'h00;
    end else if (|(upper & lower)) begin
      overlap_q <= overlap_q + 8'h01;
    end
  end
endmodule

// File: motor_pwm_deadtime_culling_tb_top.sv
/*
  Register-level tests of the dead-time and culling option block.
  Assumes the one-cycle register port and the offsets of the package.
*/
`timescale 1ns/100ps
module motor_pwm_deadtime_culling_tb_top;
  import mpd_pkg::*;
  logic clk_sys;
  logic rst_n;
  mpd_bus_req_type bus_req;
  logic [DATA_W-1:0] rdata_q, tz_q, to_q, d;
  logic [2:0] up_q, lo_q;
  logic crest, valley, adc, saw_up, saw_dn;
  logic [7:0] overlap_q;
  int n_errors = 0;
  int compares = 0;
  int g, g0, nc, nv, na;
  int culls[3] = '{1, 3, 31};

  mpd_top #(.DT_W(10)) mpd_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata_q(rdata_q),
    .tuned_compare_zero_q(tz_q), .tuned_compare_one_q(to_q), .upper_arm_outputs(up_q),
    .lower_arm_outputs(lo_q), .crest_interrupt(crest), .valley_interrupt(valley), .adc_trigger(adc));
  mpd_gate_model mpd_gate_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .upper(up_q), .lower(lo_q),
    .overlap_q(overlap_q));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 v = rdata_q;
  endtask

  // stopped writes load at once, so culling restarts from a clean count
  task automatic restart(input logic [15:0] opt1, input logic [15:0] opt2);
    wr(OFS_CTRL, 16'h0000);
    wr(OFS_OPT1, opt1);
    wr(OFS_OPT2, opt2);
    wr(OFS_CTRL, 16'h00B8);
  endtask

  // sel 0: crest to crest, sel 1: upper fall to lower rise on leg 0
  task automatic gap(input int sel, output int n);
    n = 0;
    if (sel == 1) begin
      wait (up_q[0] === 1'b1);
      @(negedge up_q[0]);
    end else begin
      @(posedge crest);
    end
    repeat (4000) begin
      @(posedge clk_sys);
      #1;
      n++;
      if ((sel == 0 && crest === 1'b1) || (sel == 1 && lo_q[0] === 1'b1)) break;
    end
  endtask

  task automatic count_win();
    nc = 0;
    nv = 0;
    na = 0;
    repeat (400) begin
      @(posedge clk_sys);
      #1;
      nc += int'(crest === 1'b1);
      nv += int'(valley === 1'b1);
      na += int'(adc === 1'b1);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    end_of_test();
  end

  initial begin
    bus_req = '0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(OFS_OPT0, d); chk("opt0 reset", 16'h0000, d);
    rd(OFS_OPT1, d); chk("opt1 reset", 16'h0000, d);
    rd(OFS_OPT2, d); chk("opt2 reset", 16'h0000, d);
    rd(OFS_DTC, d); chk("dtc reset", 16'h0000, d);
    rd(28'hFFFF6F0, d); chk("unmapped read", 16'h0000, d);
    wr(OFS_CCR_BASE, 16'h0010);
    for (int i = 1; i < 4; i++) wr(OFS_CCR_BASE + ADDR_W'(i), 16'h0008);
    wr(OFS_DTC, 16'h0003);
    rd(OFS_DTC, d); chk("dtc stopped write", 16'h0003, d);
    chk("arms stopped", 16'h0000, {10'h000, up_q, lo_q});
    restart(16'h0080, 16'h0000);
    wr(OFS_DTC, 16'h0005);
    rd(OFS_DTC, d); chk("dtc running write", 16'h0003, d);
    gap(1, g); chk("dead gap in 3..5", 16'h0001, {15'h0000, g >= 3 && g <= 5});
    saw_up = 1'b0;
    saw_dn = 1'b0;
    for (int i = 0; i < 24; i++) begin
      rd(OFS_OPT0, d);
      saw_dn |= d[OPT0_CUF];
      saw_up |= ~d[OPT0_CUF];
    end
    chk("direction seen both", 16'h0003, {14'h0000, saw_up, saw_dn});
    gap(0, g0);
    foreach (culls[i]) begin
      restart(16'h0080 | 16'(culls[i]), 16'h0080);
      gap(0, g); chk("culled crest gap", 16'((culls[i] + 1) * g0), 16'(g));
    end
    restart(16'h0040, 16'h0000);
    count_win(); chk("crest unused", 16'h0000, 16'(nc));
    chk("valley used", 16'h0001, {15'h0000, nv > 0});
    chk("adc at valleys", 16'(nv), 16'(na));
    restart(16'h0083, 16'h0080);
    wr(OFS_TUNED_BASE, 16'h1234);
    #1 chk("batch held", 16'h0000, tz_q);
    rd(OFS_TUNED_BASE, d); chk("buffer readback", 16'h1234, d);
    @(posedge crest);
    repeat (3) @(posedge clk_sys);
    #1 chk("batch after transfer", 16'h1234, tz_q);
    wr(OFS_OPT0, 16'h0004);
    rd(OFS_OPT0, d); chk("cms while running", 16'h0004, d & 16'h00FC);
    wr(OFS_TUNED_BASE, 16'h00AB);
    repeat (2) @(posedge clk_sys);
    #1 chk("anytime rewrite", 16'h00AB, tz_q);
    wr(OFS_TUNED_BASE + 28'h0000001, 16'h00CD);
    repeat (2) @(posedge clk_sys);
    #1 chk("anytime tuned one", 16'h00CD, to_q);
    wr(OFS_CTRL, 16'h0000);
    repeat (2) @(posedge clk_sys);
    #1 chk("arms after stop", 16'h0000, {10'h000, up_q, lo_q});
    chk("no shoot-through", 16'h0000, {8'h00, overlap_q});
    // one-cycle phase pulses on leg 0: narrowing shortens the lower-arm gap from 5 to 3 cycles
    wr(OFS_CCR_BASE + 28'h0000001, 16'h0001);
    for (int m = 0; m < 2; m++) begin
      restart(16'h0080, (m == 1) ? 16'h0040 : 16'h0000);
      repeat (40) @(posedge clk_sys);
      nc = 0;
      repeat (320) begin
        @(posedge clk_sys);
        #1;
        nc += int'(lo_q[0] === 1'b0);
      end
      chk("lower gap over 10 pulses", (m == 1) ? 16'h001E : 16'h0032, 16'(nc));
    end
    end_of_test();
  end
endmodule
